// [common/lfw_pkg.sv]
package lfw_pkg;

   // ***************************************************************
   // Register byte addresses (one aligned word each)
   // ***************************************************************
   localparam logic [7:0] LFW_ADDR_RX_CONTROL = 8'h00;
   localparam logic [7:0] LFW_ADDR_RX_CTRL_DATA = 8'h04;
   localparam logic [7:0] LFW_ADDR_RX_BYTE_BUF = 8'h08;
   localparam logic [7:0] LFW_ADDR_RSSI_VALUE = 8'h0c;
   localparam logic [7:0] LFW_ADDR_HEADER_CMP = 8'h10;
   localparam logic [7:0] LFW_ADDR_ID_CMP_HIGH = 8'h14;
   localparam logic [7:0] LFW_ADDR_ID_CMP_LOW = 8'h18;
   localparam logic [7:0] LFW_ADDR_IRQ_MASK = 8'h1c;
   localparam logic [7:0] LFW_ADDR_RX_FLAGS = 8'h20;

   // ***************************************************************
   // Field positions
   // ***************************************************************
   localparam int LFW_CTL_CAP_LSB = 5;
   localparam int LFW_CTL_CAP_MSB = 7;
   localparam int LFW_CTL_SENS = 4;
   localparam int LFW_CTL_MODE_LSB = 2;
   localparam int LFW_CTL_MODE_MSB = 3;
   localparam int LFW_CTL_BURST = 1;
   localparam int LFW_CTL_EN = 0;
   localparam int LFW_CDR_CAPTURE = 7;
   localparam int LFW_CDR_FE_RST = 6;
   localparam int LFW_CDR_RAW = 0;
   localparam int LFW_FLG_RSSI = 3;
   localparam int LFW_FLG_EOD = 2;
   localparam int LFW_FLG_BUF = 1;
   localparam int LFW_FLG_WAKE = 0;
   localparam logic [7:0] LFW_HDR_MASK = 8'h7f;
   localparam logic [7:0] LFW_IMR_MASK = 8'h07;
   localparam logic [7:0] LFW_RST_VAL = 8'h00;

   // ***************************************************************
   // Wake-up modes
   // ***************************************************************
   typedef enum logic [1:0]
   {
      LFW_WM_GAP = 2'b00,
      LFW_WM_HEADER = 2'b01,
      LFW_WM_HEADER_ID = 2'b10,
      LFW_WM_TRANSPARENT = 2'b11
   } lfw_wmode_t;

   localparam logic [1:0] LFW_HTRANS_NONSEQ = 2'b10;

endpackage

// [logic/lfw_flag.sv]
// Sticky event flag: hardware set wins over vector or write-one clear.
module lfw_flag
   import lfw_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   // Events
   input wire logic set_i,
   input wire logic clr_i,
   output logic flag_o
);

   typedef struct packed
   {
      logic flag;
   } lfw_flag_state_t;

   lfw_flag_state_t s_q;
   lfw_flag_state_t s_d;

   always_comb
   begin
      s_d = s_q;
      if (clr_i)
      begin
         s_d.flag = 1'b0;
      end
      if (set_i)
      begin
         s_d.flag = 1'b1;
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign flag_o = s_q.flag;

endmodule // lfw_flag

// [logic/lfw_regs.sv]
// What this block does
// R1 - Three capacitance select bits choose the antenna trimming capacitor.
// R2 - Sensitivity bit: zero high sensitivity (default), one low sensitivity.
// R3 - Two-bit wake-up mode: gap, header, header plus identifier, transparent.
// R4 - Preamble bit one selects burst detection, zero continuous detection.
// R5 - Enable bit turns the receiver on when one, off when zero.
// R6 - Capture bit takes one 7-bit strength sample, only while enabled.
// R7 - Capture bit clears itself once the sample is stored.
// R8 - Strength register is readable while reception keeps running.
// R9 - In transparent mode software pulses reset bit; release returns to standby.
// R10 - Outside transparent mode reset bit is ignored; standby return is automatic.
// R11 - Reserved bits always read zero.
// R12 - Raw demodulated bit is readable after a start gap was detected.
// R13 - Receive buffer loads each decoded 8-bit frame.
// R14 - Header compare holds seven writable bits; top bit read-only.
// R15 - Software writes identifier high byte before low byte.
// R16 - Software reads identifier low byte before high byte.
// R17 - Transmitter should avoid periodic header or identifier patterns.
// R18 - Mask bit 2 gates end-of-data interrupt with global enable.
// R19 - Mask bit 1 gates buffer-full interrupt with global enable.
// R20 - Mask bit 0 gates wake-up interrupt with global enable.
// R21 - Strength-ready flag sets when value loaded; write one clears.
// R22 - Buffer-full flag sets on new byte; vector or write one clears.
// R23 - End-of-data flag sets on error, completion or timeout; clears likewise.
// R24 - Wake-up flag sets on wake-up; vector or write one clears.
// R25 - Identifier high write buffered until low write; low read latches high.
// R26 - Control, mask and compare registers reset to zero.
module lfw_regs
   import lfw_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   // AHB-Lite slave
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   // Front-end controls
   output logic [2:0] trim_cap_select_o,
   output logic sensitivity_select_o,
   output logic [1:0] wakeup_mode_select_o,
   output logic burst_preamble_mode_o,
   output logic receiver_enable_o,
   output logic front_end_reset_o,
   output logic [7:0] header_compare_o,
   output logic [15:0] identifier_compare_o,
   // Front-end and decoder status
   input wire logic [6:0] agc_strength_i,
   input wire logic demod_data_i,
   input wire logic start_gap_seen_i,
   input wire logic byte_valid_i,
   input wire logic [7:0] byte_data_i,
   input wire logic end_of_data_i,
   input wire logic wakeup_i,
   // Interrupt controller
   input wire logic global_irq_enable_i,
   input wire logic wakeup_vector_ack_i,
   input wire logic rx_buffer_vector_ack_i,
   input wire logic end_of_burst_vector_ack_i,
   output logic wakeup_irq_o,
   output logic rx_buffer_irq_o,
   output logic end_of_data_irq_o
);

   // ***************************************************************
   // State
   // ***************************************************************
   typedef struct packed
   {
      logic [7:0] ctl;
      logic capture;
      logic fe_rst;
      logic [7:0] rx_byte;
      logic [6:0] rssi;
      logic rssi_set;
      logic [6:0] hdr;
      logic [7:0] id_high;
      logic [7:0] id_low;
      logic [7:0] id_high_buf;
      logic [7:0] id_high_rd;
      logic [2:0] imr;
      logic raw;
      logic wr_pend;
      logic [7:0] addr;
      logic [31:0] rdata;
   } lfw_regs_state_t;

   lfw_regs_state_t s_q;
   lfw_regs_state_t s_d;

   logic rssi_flag;
   logic eod_flag;
   logic buf_flag;
   logic wake_flag;
   logic addr_ph;
   logic wr_now;
   logic rd_now;
   logic [7:0] wbyte;
   logic [7:0] flag_wr;
   logic [7:0] rd_val;

   assign addr_ph = hsel_i && hready_i && htrans_i == LFW_HTRANS_NONSEQ;
   assign rd_now = addr_ph && !hwrite_i;
   assign wr_now = s_q.wr_pend;
   assign wbyte = hwdata_i[7:0];
   assign flag_wr = (wr_now && s_q.addr == LFW_ADDR_RX_FLAGS) ? wbyte : LFW_RST_VAL;

   // ***************************************************************
   // Read multiplexer
   // ***************************************************************
   always_comb
   begin
      rd_val = LFW_RST_VAL; // R11
      case (haddr_i[7:0])
         LFW_ADDR_RX_CONTROL: rd_val = s_q.ctl;
         LFW_ADDR_RX_CTRL_DATA: rd_val = {s_q.capture, s_q.fe_rst, 5'h00, s_q.raw}; // R11
         LFW_ADDR_RX_BYTE_BUF: rd_val = s_q.rx_byte;
         LFW_ADDR_RSSI_VALUE: rd_val = {1'b0, s_q.rssi}; // R8
         LFW_ADDR_HEADER_CMP: rd_val = {1'b0, s_q.hdr}; // R14
         LFW_ADDR_ID_CMP_HIGH: rd_val = s_q.id_high_rd; // R25
         LFW_ADDR_ID_CMP_LOW: rd_val = s_q.id_low;
         LFW_ADDR_IRQ_MASK: rd_val = {5'h00, s_q.imr}; // R11
         LFW_ADDR_RX_FLAGS: rd_val = {4'h0, rssi_flag, eod_flag, buf_flag, wake_flag};
         default: rd_val = LFW_RST_VAL;
      endcase
   end

   // ***************************************************************
   // Next state
   // ***************************************************************
   always_comb
   begin
      s_d = s_q;
      s_d.rssi_set = 1'b0;
      s_d.wr_pend = addr_ph && hwrite_i;
      if (addr_ph)
      begin
         s_d.addr = haddr_i[7:0];
      end
      if (rd_now)
      begin
         s_d.rdata = {24'h000000, rd_val};
         if (haddr_i[7:0] == LFW_ADDR_ID_CMP_LOW)
         begin
            s_d.id_high_rd = s_q.id_high; // R25
         end
      end
      if (wr_now)
      begin
         case (s_q.addr)
            LFW_ADDR_RX_CONTROL: s_d.ctl = wbyte; // R1 R2 R3 R4 R5
            LFW_ADDR_RX_CTRL_DATA:
            begin
               s_d.capture = wbyte[LFW_CDR_CAPTURE] | s_q.capture; // R6
               s_d.fe_rst = wbyte[LFW_CDR_FE_RST];
            end
            LFW_ADDR_HEADER_CMP: s_d.hdr = wbyte[6:0] & LFW_HDR_MASK[6:0]; // R14
            LFW_ADDR_ID_CMP_HIGH:
            begin
               s_d.id_high_buf = wbyte; // R25
               s_d.id_high_rd = wbyte;
            end
            LFW_ADDR_ID_CMP_LOW:
            begin
               s_d.id_low = wbyte; // R25
               s_d.id_high = s_q.id_high_buf;
            end
            LFW_ADDR_IRQ_MASK: s_d.imr = wbyte[2:0] & LFW_IMR_MASK[2:0];
            default:
            begin
            end
         endcase
      end
      // A capture request while disabled waits until the receiver runs.
      if (s_q.capture && s_q.ctl[LFW_CTL_EN])
      begin
         s_d.rssi = agc_strength_i; // R6
         s_d.rssi_set = 1'b1; // R21
         s_d.capture = 1'b0; // R7
      end
      if (byte_valid_i)
      begin
         s_d.rx_byte = byte_data_i; // R13
      end
      s_d.raw = start_gap_seen_i ? demod_data_i : 1'b0; // R12
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         s_q <= '0; // R26
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // ***************************************************************
   // Flags
   // ***************************************************************
   lfw_flag u_flag_rssi
   (
      .core_clk_i(core_clk_i),
      .arst_n_i(arst_n_i),
      .set_i(s_q.rssi_set), // R21
      .clr_i(flag_wr[LFW_FLG_RSSI]),
      .flag_o(rssi_flag)
   );

   lfw_flag u_flag_eod
   (
      .core_clk_i(core_clk_i),
      .arst_n_i(arst_n_i),
      .set_i(end_of_data_i), // R23
      .clr_i(flag_wr[LFW_FLG_EOD] | end_of_burst_vector_ack_i),
      .flag_o(eod_flag)
   );

   lfw_flag u_flag_buf
   (
      .core_clk_i(core_clk_i),
      .arst_n_i(arst_n_i),
      .set_i(byte_valid_i), // R22
      .clr_i(flag_wr[LFW_FLG_BUF] | rx_buffer_vector_ack_i),
      .flag_o(buf_flag)
   );

   lfw_flag u_flag_wake
   (
      .core_clk_i(core_clk_i),
      .arst_n_i(arst_n_i),
      .set_i(wakeup_i), // R24
      .clr_i(flag_wr[LFW_FLG_WAKE] | wakeup_vector_ack_i),
      .flag_o(wake_flag)
   );

   // ***************************************************************
   // Outputs
   // ***************************************************************
   assign trim_cap_select_o = s_q.ctl[LFW_CTL_CAP_MSB:LFW_CTL_CAP_LSB]; // R1
   assign sensitivity_select_o = s_q.ctl[LFW_CTL_SENS]; // R2
   assign wakeup_mode_select_o = s_q.ctl[LFW_CTL_MODE_MSB:LFW_CTL_MODE_LSB]; // R3
   assign burst_preamble_mode_o = s_q.ctl[LFW_CTL_BURST]; // R4
   assign receiver_enable_o = s_q.ctl[LFW_CTL_EN]; // R5
   // The reset bit reaches the front end only in transparent mode.
   assign front_end_reset_o = s_q.fe_rst
      && (wakeup_mode_select_o == LFW_WM_TRANSPARENT); // R9 R10
   assign header_compare_o = {1'b0, s_q.hdr};
   assign identifier_compare_o = {s_q.id_high, s_q.id_low};
   assign end_of_data_irq_o = global_irq_enable_i && s_q.imr[LFW_FLG_EOD] && eod_flag; // R18
   assign rx_buffer_irq_o = global_irq_enable_i && s_q.imr[LFW_FLG_BUF] && buf_flag; // R19
   assign wakeup_irq_o = global_irq_enable_i && s_q.imr[LFW_FLG_WAKE] && wake_flag; // R20
   assign hrdata_o = s_q.rdata;
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;

endmodule // lfw_regs

// [testbench/lfw_regs_chk.sv]
module lfw_regs_chk
   import lfw_pkg::*;
(
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   // Bus
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic hready_i,
   input wire logic [31:0] hrdata_o,
   input wire logic hreadyout_o,
   input wire logic hresp_o,
   // Registered outputs
   input wire logic [2:0] trim_cap_select_o,
   input wire logic [1:0] wakeup_mode_select_o,
   input wire logic front_end_reset_o,
   input wire logic [15:0] identifier_compare_o,
   // Interrupts
   input wire logic global_irq_enable_i,
   input wire logic wakeup_irq_o,
   input wire logic rx_buffer_irq_o,
   input wire logic end_of_data_irq_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****
   // Bus and register relations
   // ****
   logic take, wr_ctl, wr_idl;
   assign take = hsel_i && hready_i && hwrite_i && htrans_i == LFW_HTRANS_NONSEQ;
   assign wr_ctl = take && haddr_i[7:0] == LFW_ADDR_RX_CONTROL;
   assign wr_idl = take && haddr_i[7:0] == LFW_ADDR_ID_CMP_LOW;
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);
   a_bus_okay: assert property (hreadyout_o && !hresp_o) else $error("bus answer wrong");
   a_rdata_zero: assert property (hrdata_o[31:8] == 24'h0) else $error("upper read bits set");
   a_reset_mode: assert property (front_end_reset_o |-> wakeup_mode_select_o == LFW_WM_TRANSPARENT)
      else $error("front end reset outside transparent mode");
   a_reset_cause: assert property ($rose(front_end_reset_o) |-> $past(take, 2))
      else $error("front end reset without a write");
   a_ctl_write: assert property (!$stable(trim_cap_select_o) |-> $past(wr_ctl, 2))
      else $error("trim changed without control write");
   a_id_commit: assert property (!$stable(identifier_compare_o) |-> $past(wr_idl, 2))
      else $error("identifier changed without low write");
   a_wake_gate: assert property (wakeup_irq_o |-> global_irq_enable_i)
      else $error("wake irq without global enable");
   a_buf_gate: assert property (rx_buffer_irq_o |-> global_irq_enable_i)
      else $error("buffer irq without global enable");
   a_eod_gate: assert property (end_of_data_irq_o |-> global_irq_enable_i)
      else $error("end irq without global enable");
endmodule // lfw_regs_chk

bind lfw_regs lfw_regs_chk u_chk (.core_clk_i, .arst_n_i, .hsel_i, .haddr_i, .htrans_i,
   .hwrite_i, .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .trim_cap_select_o,
   .wakeup_mode_select_o, .front_end_reset_o, .identifier_compare_o, .global_irq_enable_i,
   .wakeup_irq_o, .rx_buffer_irq_o, .end_of_data_irq_o);

// [testbench/lfw_fe_model.sv]
module lfw_fe_model
   import lfw_pkg::*;
(
   input wire logic core_clk_i,
   output logic [6:0] agc_o,
   output logic demod_o,
   output logic gap_o,
   output logic [2:0] event_o,
   output logic [7:0] byte_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****
   // Front end stand-in
   // ****
   initial
   begin
      {agc_o, demod_o, gap_o, event_o, byte_o} = '0;
   end
   task automatic level(input logic [6:0] a, input logic d, input logic g);
      agc_o <= a;
      demod_o <= d;
      gap_o <= g;
   endtask
   // Byte lines flip once the strobe drops, so a late sample is caught.
   task automatic pulse(input logic [2:0] m, input logic [7:0] b);
      event_o <= m;
      byte_o <= b;
      @(posedge core_clk_i);
      event_o <= 3'b000;
      byte_o <= ~b;
      @(posedge core_clk_i);
   endtask
endmodule // lfw_fe_model

// [testbench/tb_top.sv]
module tb_top import lfw_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0] htrans = 2'b00, mode;
   logic hwrite = 1'b0, gie = 1'b0, hready, hresp, sens, burst, en, fer, demod, gap;
   logic [2:0] ack = 3'b000, cap, irq, ev;
   logic [7:0] hdr, bd;
   logic [15:0] idc;
   logic [6:0] agc;
   int miscompares = 0;
   int n_tests = 0;
   lfw_regs uut (.core_clk_i(clk), .arst_n_i(rst_n), .hsel_i(1'b1), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata),
      .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
      .trim_cap_select_o(cap), .sensitivity_select_o(sens), .wakeup_mode_select_o(mode),
      .burst_preamble_mode_o(burst), .receiver_enable_o(en), .front_end_reset_o(fer),
      .header_compare_o(hdr), .identifier_compare_o(idc), .agc_strength_i(agc),
      .demod_data_i(demod), .start_gap_seen_i(gap), .byte_valid_i(ev[1]), .byte_data_i(bd),
      .end_of_data_i(ev[2]), .wakeup_i(ev[0]), .global_irq_enable_i(gie),
      .wakeup_vector_ack_i(ack[0]), .rx_buffer_vector_ack_i(ack[1]),
      .end_of_burst_vector_ack_i(ack[2]), .wakeup_irq_o(irq[0]), .rx_buffer_irq_o(irq[1]),
      .end_of_data_irq_o(irq[2]));
   lfw_fe_model fe (.core_clk_i(clk), .agc_o(agc), .demod_o(demod), .gap_o(gap),
      .event_o(ev), .byte_o(bd));
   initial
   begin
      forever #50 clk = ~clk;
   end
   // ****
   // Helpers
   // ****
   task automatic tally_and_finish();
      $display("tests %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // A stalled bus must not hang the run.
   task automatic step();
      int n;
      n = 0;
      @(posedge clk);
      while (hready !== 1'b1)
      begin
         n++;
         if (n > 20)
         begin
            miscompares++;
            tally_and_finish();
         end
         @(posedge clk);
      end
   endtask
   task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= LFW_HTRANS_NONSEQ;
      step();
      htrans <= 2'b00;
      hwdata <= {24'h0, d};
      step();
      rd = hrdata;
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      bus(a, 1'b0, 8'h00);
      check(rd, {24'h0, e});
   endtask
   task automatic ack_pulse(input logic [2:0] m);
      ack <= m;
      @(posedge clk);
      ack <= 3'b000;
      @(posedge clk);
   endtask
   // ****
   // Scenarios
   // ****
   task automatic t_ctrl();
      logic [7:0] d;
      for (int a = 0; a <= 36; a += 4)
         rc(8'(a), 8'h00);
      for (int i = 0; i < 5; i++)
      begin
         d = (i == 4) ? 8'hff : 8'(37 * i);
         bus(LFW_ADDR_RX_CONTROL, 1'b1, d);
         @(posedge clk);
         check({cap, sens, mode, burst, en}, d);
         rc(LFW_ADDR_RX_CONTROL, d);
      end
      $display("test control done");
   endtask
   task automatic t_rssi();
      bus(LFW_ADDR_RX_CONTROL, 1'b1, 8'h00);
      fe.level(7'h55, 1'b1, 1'b0);
      bus(LFW_ADDR_RX_CTRL_DATA, 1'b1, 8'h80);
      rc(LFW_ADDR_RSSI_VALUE, 8'h00);
      rc(LFW_ADDR_RX_CTRL_DATA, 8'h80);
      bus(LFW_ADDR_RX_CONTROL, 1'b1, 8'h01);
      repeat (2) @(posedge clk);
      fe.level(7'h2a, 1'b1, 1'b0);
      rc(LFW_ADDR_RSSI_VALUE, 8'h55);
      rc(LFW_ADDR_RX_CTRL_DATA, 8'h00);
      rc(LFW_ADDR_RX_FLAGS, 8'h08);
      bus(LFW_ADDR_RX_FLAGS, 1'b1, 8'h08);
      rc(LFW_ADDR_RX_FLAGS, 8'h00);
      $display("test rssi done");
   endtask
   task automatic t_fe();
      bus(LFW_ADDR_RX_CTRL_DATA, 1'b1, 8'h40);
      rc(LFW_ADDR_RX_CTRL_DATA, 8'h40);
      for (int m = 0; m < 4; m++)
      begin
         bus(LFW_ADDR_RX_CONTROL, 1'b1, 8'(m * 4 + 1));
         @(posedge clk);
         check(fer, m == 3);
      end
      bus(LFW_ADDR_RX_CTRL_DATA, 1'b1, 8'h00);
      @(posedge clk);
      check(fer, 1'b0);
      for (int i = 0; i < 3; i++)
      begin
         fe.level(7'h00, i != 2, i != 0);
         repeat (2) @(posedge clk);
         rc(LFW_ADDR_RX_CTRL_DATA, 8'(i == 1));
      end
      $display("test front end done");
   endtask
   task automatic t_irq();
      bus(LFW_ADDR_IRQ_MASK, 1'b1, 8'hff);
      rc(LFW_ADDR_IRQ_MASK, 8'h07);
      gie <= 1'b1;
      fe.pulse(3'b010, 8'ha5);
      rc(LFW_ADDR_RX_BYTE_BUF, 8'ha5);
      check(irq, 3'b010);
      ack_pulse(3'b010);
      check(irq, 3'b000);
      fe.pulse(3'b001, 8'h00);
      check(irq, 3'b001);
      bus(LFW_ADDR_RX_FLAGS, 1'b1, 8'h01);
      rc(LFW_ADDR_RX_FLAGS, 8'h00);
      fe.pulse(3'b100, 8'h00);
      check(irq, 3'b100);
      gie <= 1'b0;
      @(posedge clk);
      check(irq, 3'b000);
      ack_pulse(3'b100);
      bus(LFW_ADDR_IRQ_MASK, 1'b1, 8'h00);
      gie <= 1'b1;
      fe.pulse(3'b111, 8'h3c);
      check(irq, 3'b000);
      rc(LFW_ADDR_RX_FLAGS, 8'h07);
      ack_pulse(3'b111);
      rc(LFW_ADDR_RX_FLAGS, 8'h00);
      $display("test interrupts done");
   endtask
   task automatic t_id();
      // Compare patterns are kept aperiodic so the receiver cannot lock on a repeat.
      bus(LFW_ADDR_HEADER_CMP, 1'b1, 8'hcd);
      rc(LFW_ADDR_HEADER_CMP, 8'h4d);
      check(hdr, 8'h4d);
      bus(LFW_ADDR_ID_CMP_HIGH, 1'b1, 8'h12);
      @(posedge clk);
      check(idc, 16'h0000);
      bus(LFW_ADDR_ID_CMP_LOW, 1'b1, 8'h34);
      @(posedge clk);
      check(idc, 16'h1234);
      rc(LFW_ADDR_ID_CMP_LOW, 8'h34);
      rc(LFW_ADDR_ID_CMP_HIGH, 8'h12);
      // A lone high write must not commit, and a low read must latch the committed high byte.
      bus(LFW_ADDR_ID_CMP_HIGH, 1'b1, 8'h56);
      @(posedge clk);
      check(idc, 16'h1234);
      rc(LFW_ADDR_ID_CMP_LOW, 8'h34);
      rc(LFW_ADDR_ID_CMP_HIGH, 8'h12);
      bus(LFW_ADDR_ID_CMP_LOW, 1'b1, 8'h78);
      @(posedge clk);
      check(idc, 16'h5678);
      $display("test identifier done");
   endtask
   initial
   begin
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_ctrl();
      t_rssi();
      t_fe();
      t_irq();
      t_id();
      tally_and_finish();
   end
endmodule // tb_top
